// file: rtl/cfsg_top.sv
// Clock source select, synchronous output gate and nine-way fanout
//
// Contract
// - Select low routes input a, high input b
// - All nine outputs carry the same clock
// - Gate high passes clock, low holds low
// - Gate sampled on selected clock falling edge
// - Gating never truncates a pulse
// - Float control low floats every output
// - Control inputs read as high only from reset until the input stage samples the pins
`timescale 1ns/1ps
`default_nettype none
module cfsg_top
    import cfsg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Clock sources
    input wire logic clock_input_a_in,
    input wire logic clock_input_b_in,
    // Controls
    input wire logic clock_source_select_in,
    input wire logic sync_gate_in,
    input wire logic output_float_n_in,
    // Clock loads
    output var logic [cfsg_pkg::NUM_OUTPUTS-1:0] clock_out,
    output var logic [cfsg_pkg::NUM_OUTPUTS-1:0] clock_oe_n_out
);
    import cfsg_pkg::*;

    function automatic logic pick_source(input logic sel, input logic a, input logic b);
        pick_source = sel ? b : a;
    endfunction : pick_source

    logic [NUM_PINS-1:0] pins_raw;
    logic [NUM_PINS-1:0] pins;
    logic sel_level;
    logic prev_level;
    logic next_prev_level;
    logic falling;
    logic gate;
    logic next_gate;
    logic next_out_level;
    logic next_oe_n;
    logic [NUM_OUTPUTS-1:0] next_clock;
    logic [NUM_OUTPUTS-1:0] next_clock_oe_n;

    always_comb
    begin
        pins_raw = '0;
        pins_raw[PIN_CLOCK_A] = clock_input_a_in;
        pins_raw[PIN_CLOCK_B] = clock_input_b_in;
        pins_raw[PIN_SELECT] = clock_source_select_in;
        pins_raw[PIN_GATE] = sync_gate_in;
        pins_raw[PIN_FLOAT_N] = output_float_n_in;
    end

    cfsg_input_stage u_input_stage (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pins_in(pins_raw),
        .pins_out(pins)
    );

    // Gate state: takes the gate pin only when the chosen clock falls
    always_comb
    begin
        sel_level = pick_source(pins[PIN_SELECT], pins[PIN_CLOCK_A], pins[PIN_CLOCK_B]);
        next_prev_level = sel_level;
        falling = prev_level && !sel_level;
        next_gate = gate;
        if (falling)
        begin
            next_gate = pins[PIN_GATE];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            prev_level <= LEVEL_RESET_VALUE;
            gate <= GATE_RESET_VALUE;
        end
        else
        begin
            prev_level <= next_prev_level;
            gate <= next_gate;
        end
    end

    // The gate only moves while the clock is low, so the AND can never clip a high phase
    always_comb
    begin
        next_out_level = sel_level && gate;
        next_oe_n = !pins[PIN_FLOAT_N];
    end

    // One flop per output; a shared flop would be simpler but every load gets its own driver
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUTPUTS; gi++)
        begin : g_fanout
            always_comb
            begin
                next_clock[gi] = next_out_level;
                next_clock_oe_n[gi] = next_oe_n;
            end

            always_ff @(posedge clk_in)
            begin
                if (reset_in)
                begin
                    clock_out[gi] <= CLOCK_OUT_RESET_VALUE[gi];
                    clock_oe_n_out[gi] <= OE_N_RESET_VALUE[gi];
                end
                else
                begin
                    clock_out[gi] <= next_clock[gi];
                    clock_oe_n_out[gi] <= next_clock_oe_n[gi];
                end
            end
        end
    endgenerate

    // Checks

    property p_source_a;
        @(posedge clk_in) disable iff (reset_in)
        (gate && !pins[PIN_SELECT]) |=> (clock_out[0] == $past(pins[PIN_CLOCK_A]));
    endproperty
    a_source_a: assert property (p_source_a) else $error("input a not routed");

    property p_source_b;
        @(posedge clk_in) disable iff (reset_in)
        (gate && pins[PIN_SELECT]) |=> (clock_out[0] == $past(pins[PIN_CLOCK_B]));
    endproperty
    a_source_b: assert property (p_source_b) else $error("input b not routed");

    property p_fanout_equal;
        @(posedge clk_in) disable iff (reset_in)
        ##1 (clock_out == {NUM_OUTPUTS{clock_out[0]}}) && (clock_oe_n_out == {NUM_OUTPUTS{clock_oe_n_out[0]}});
    endproperty
    a_fanout_equal: assert property (p_fanout_equal) else $error("outputs differ");

    property p_gate_low_holds;
        @(posedge clk_in) disable iff (reset_in)
        !gate |=> (clock_out == '0);
    endproperty
    a_gate_low_holds: assert property (p_gate_low_holds) else $error("output not held low");

    property p_gate_on_fall;
        @(posedge clk_in) disable iff (reset_in)
        $changed(gate) |-> ($past(prev_level) && !$past(sel_level) && gate == $past(pins[PIN_GATE]));
    endproperty
    a_gate_on_fall: assert property (p_gate_on_fall) else $error("gate moved off falling edge");

    property p_no_runt_rise;
        @(posedge clk_in) disable iff (reset_in)
        $rose(clock_out[0]) |-> !$past(sel_level, 2);
    endproperty
    a_no_runt_rise: assert property (p_no_runt_rise) else $error("clipped low phase");

    property p_no_runt_fall;
        @(posedge clk_in) disable iff (reset_in)
        $fell(clock_out[0]) |-> ($past(sel_level, 2) && !$past(sel_level));
    endproperty
    a_no_runt_fall: assert property (p_no_runt_fall) else $error("clipped high phase");

    property p_float;
        @(posedge clk_in) disable iff (reset_in)
        !pins[PIN_FLOAT_N] |=> (clock_oe_n_out == {NUM_OUTPUTS{1'b1}});
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated");

    property p_drive;
        @(posedge clk_in) disable iff (reset_in)
        pins[PIN_FLOAT_N] |=> (clock_oe_n_out == '0);
    endproperty
    a_drive: assert property (p_drive) else $error("outputs not driven");

    property p_pullup_default;
        @(posedge clk_in) disable iff (reset_in)
        $past(reset_in) |-> (pins == PIN_RESET_VALUE);
    endproperty
    a_pullup_default: assert property (p_pullup_default) else $error("inputs not high after reset");

    property p_float_overrides;
        @(posedge clk_in) disable iff (reset_in)
        (!pins[PIN_FLOAT_N] && gate && sel_level) |=> (clock_oe_n_out[0] && clock_out[0]);
    endproperty
    a_float_overrides: assert property (p_float_overrides) else $error("float lost to gate");

    property p_gate_taken;
        @(posedge clk_in) disable iff (reset_in)
        (prev_level && !sel_level) |=> (gate == $past(pins[PIN_GATE]));
    endproperty
    a_gate_taken: assert property (p_gate_taken) else $error("gate not taken on falling edge");

    property p_gate_high_passes;
        @(posedge clk_in) disable iff (reset_in)
        (gate && sel_level) |=> (clock_out == {NUM_OUTPUTS{1'h1}});
    endproperty
    a_gate_high_passes: assert property (p_gate_high_passes) else $error("enabled clock not passed");

    property p_gate_moves_low;
        @(posedge clk_in) disable iff (reset_in)
        $changed(gate) |-> !$past(sel_level);
    endproperty
    a_gate_moves_low: assert property (p_gate_moves_low) else $error("gate moved while clock high");

    property p_pullup_drives;
        @(posedge clk_in) disable iff (reset_in)
        $past(reset_in) |=> (clock_oe_n_out == '0);
    endproperty
    a_pullup_drives: assert property (p_pullup_drives) else $error("float input not read high");

    property p_float_parked;
        @(posedge clk_in) disable iff (reset_in)
        (!pins[PIN_FLOAT_N] && !gate) |=> ((clock_oe_n_out == {NUM_OUTPUTS{1'h1}}) && (clock_out == '0));
    endproperty
    a_float_parked: assert property (p_float_parked) else $error("disabled outputs not floated low");
endmodule : cfsg_top
`default_nettype wire

// file: rtl/cfsg_pkg.sv
// Constants shared by the clock fanout, select and gate block
package cfsg_pkg;
    localparam int NUM_OUTPUTS = 9;
    localparam int NUM_PINS = 5;
    // Input stage bit positions
    localparam int PIN_CLOCK_A = 0;
    localparam int PIN_CLOCK_B = 1;
    localparam int PIN_SELECT = 2;
    localparam int PIN_GATE = 3;
    localparam int PIN_FLOAT_N = 4;
    // Every control input idles high, as its pull-up would make it
    localparam logic [NUM_PINS-1:0] PIN_RESET_VALUE = 5'h1F;
    localparam logic GATE_RESET_VALUE = 1'h0;
    localparam logic LEVEL_RESET_VALUE = 1'h1;
    localparam logic [NUM_OUTPUTS-1:0] CLOCK_OUT_RESET_VALUE = 9'h000;
    // Output enables are active low; reset leaves the pins floating
    localparam logic [NUM_OUTPUTS-1:0] OE_N_RESET_VALUE = 9'h1FF;
endpackage : cfsg_pkg

// file: rtl/cfsg_input_stage.sv
// Registered sampling stage for the clock and control pins
`timescale 1ns/1ps
`default_nettype none
module cfsg_input_stage
    import cfsg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pins
    input wire logic [cfsg_pkg::NUM_PINS-1:0] pins_in,
    output var logic [cfsg_pkg::NUM_PINS-1:0] pins_out
);
    import cfsg_pkg::*;

    logic [NUM_PINS-1:0] next_pins;

    always_comb
    begin
        next_pins = pins_in;
    end

    // Reset value stands in for the pull-ups until real levels arrive
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pins_out <= PIN_RESET_VALUE;
        end
        else
        begin
            pins_out <= next_pins;
        end
    end
endmodule : cfsg_input_stage
`default_nettype wire

// file: testbench/cfsg_partner.sv
// Clock sources and clock loads beside the fanout block
`timescale 1ns/1ps
`default_nettype none
module cfsg_partner
    import cfsg_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Sources
    output var logic clock_a_out,
    output var logic clock_b_out,
    // Loads
    input wire logic [cfsg_pkg::NUM_OUTPUTS-1:0] clock_in,
    input wire logic [cfsg_pkg::NUM_OUTPUTS-1:0] oe_n_in,
    output wire [cfsg_pkg::NUM_OUTPUTS-1:0] load_out
);
    int count = 0;
    // Unequal periods so a wrong select shows up quickly
    always @(posedge clk_in)
    begin
        #1;
        count = count + 1;
        clock_a_out = count[1];
        clock_b_out = (count % 6) >= 3;
    end
    for (genvar i = 0; i < NUM_OUTPUTS; i++)
    begin : g_load
        assign load_out[i] = oe_n_in[i] ? 1'bz : clock_in[i];
    end
endmodule : cfsg_partner
`default_nettype wire

// file: testbench/cfsg_top_tb_top.sv
// Self-checking bench for the clock fanout, select and gate block
`timescale 1ns/1ps
`default_nettype none
module cfsg_top_tb_top;
    import cfsg_pkg::*;
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic sel = 1'h0;
    logic gate = 1'h0;
    logic float_n = 1'h1;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    wire logic clk_a;
    wire logic clk_b;
    wire logic [NUM_OUTPUTS-1:0] q;
    wire logic [NUM_OUTPUTS-1:0] oe_n;
    wire [NUM_OUTPUTS-1:0] load;
    logic [NUM_PINS-1:0] st;
    logic prev_src;
    logic gate_m;
    logic [NUM_OUTPUTS-1:0] exp_q;
    logic [NUM_OUTPUTS-1:0] exp_oe;
    wire logic src = st[PIN_SELECT] ? st[PIN_CLOCK_B] : st[PIN_CLOCK_A];
    cfsg_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .clock_input_a_in(clk_a), .clock_input_b_in(clk_b),
        .clock_source_select_in(sel), .sync_gate_in(gate), .output_float_n_in(float_n),
        .clock_out(q), .clock_oe_n_out(oe_n));
    cfsg_partner u_partner (.clk_in(clk_in), .clock_a_out(clk_a), .clock_b_out(clk_b),
        .clock_in(q), .oe_n_in(oe_n), .load_out(load));
    initial forever #4 clk_in = ~clk_in;
    // Expected outputs: two-stage latency, gate taken only on a sampled falling source
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st <= PIN_RESET_VALUE;
            prev_src <= 1'h1;
            gate_m <= GATE_RESET_VALUE;
            exp_q <= CLOCK_OUT_RESET_VALUE;
            exp_oe <= OE_N_RESET_VALUE;
        end
        else
        begin
            st <= {float_n, gate, sel, clk_b, clk_a};
            prev_src <= src;
            if (prev_src && !src)
                gate_m <= st[PIN_GATE];
            exp_q <= gate_m ? {NUM_OUTPUTS{src}} : '0;
            exp_oe <= {NUM_OUTPUTS{~st[PIN_FLOAT_N]}};
        end
    end
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            num_errors = num_errors + 1;
            summarize();
        end
    end
    task automatic check(input string name, input logic [NUM_OUTPUTS-1:0] seen, input logic [NUM_OUTPUTS-1:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic run(input int n);
        repeat (n)
        begin
            @(negedge clk_in);
            check("clock_out", q, exp_q);
            check("clock_oe_n_out", oe_n, exp_oe);
            check("load", load, exp_oe[0] ? {NUM_OUTPUTS{1'bz}} : exp_q);
        end
    endtask : run
    task automatic set_pins(input logic s, input logic g, input logic f);
        @(posedge clk_in);
        #1;
        sel = s;
        gate = g;
        float_n = f;
    endtask : set_pins
    task automatic t_reset();
        repeat (3) @(negedge clk_in);
        check("clock_out", q, CLOCK_OUT_RESET_VALUE);
        check("clock_oe_n_out", oe_n, OE_N_RESET_VALUE);
    endtask : t_reset
    task automatic t_select();
        set_pins(1'h0, 1'h1, 1'h1);
        run(40);
        set_pins(1'h1, 1'h1, 1'h1);
        run(40);
    endtask : t_select
    task automatic t_gate();
        set_pins(1'h1, 1'h0, 1'h1);
        run(14);
        // One-cycle gate pulses must only count if they meet a falling edge
        set_pins(1'h1, 1'h1, 1'h1);
        set_pins(1'h1, 1'h0, 1'h1);
        run(14);
        set_pins(1'h1, 1'h1, 1'h1);
        run(20);
    endtask : t_gate
    task automatic t_float();
        set_pins(1'h0, 1'h1, 1'h0);
        run(12);
        set_pins(1'h0, 1'h0, 1'h0);
        run(12);
        set_pins(1'h0, 1'h1, 1'h1);
        run(20);
    endtask : t_float
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial
    begin
        t_reset();
        repeat (9) @(posedge clk_in);
        #1;
        reset_in = 1'h0;
        t_select();
        t_gate();
        t_float();
        summarize();
    end
endmodule : cfsg_top_tb_top
`default_nettype wire
